// [verilog/uart_rx_pkg.sv]
// Purpose: shared constants for the serial receive/status block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: all offsets and field positions live here, with the CTLB, CTLC, BAUD and UDRE reset values
package uart_rx_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STA = 8'h04;
  localparam logic [7:0] OFF_CTLB = 8'h08;
  localparam logic [7:0] OFF_CTLC = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // serial_status_control_a fields
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_UPE = 2;
  localparam int A_U2X = 1;
  localparam int A_MPCM = 0;
  // serial_control_b fields
  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_SZ2 = 2;
  localparam int B_RXB8 = 1;
  localparam int B_TXB8 = 0;
  // frame control fields
  localparam int C_SZ_LO = 0;
  localparam int C_PAR_EN = 2;
  localparam int C_PAR_ODD = 3;
  localparam int C_SYNC = 4;
  localparam int C_GIE = 5;
  // sticky event bits
  localparam int EV_RX = 0;
  localparam int EV_FE = 1;
  localparam int EV_DOR = 2;
  localparam int EV_TXC = 3;
  localparam int EV_W = 4;
  // reset values
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [7:0] CTLC_RST = 8'h03;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic UDRE_RST = 1'b1;
  // samples per bit
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  // buffer entry layout
  localparam int ENTRY_W = 12;
  localparam int E_DOR = 11;
  localparam int E_PE = 10;
  localparam int E_FE = 9;
  localparam logic [2:0] SZ_NINE = 3'h7;

  // data bits per character; reserved codes fall back to eight
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == SZ_NINE) begin
      return 4'h9;
    end else if (!code[2]) begin
      return 4'h5 + {2'h0, code[1:0]};
    end
    return 4'h8;
  endfunction : char_bits
endpackage : uart_rx_pkg

// [verilog/rx_buffer.sv]
// Purpose: two-entry receive buffer with registered head
// Assumes: no push while full, no pop while empty
// Notes: head_r always shows the oldest entry, zero when empty
`timescale 1ns/1ps
module rx_buffer
  import uart_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic [ENTRY_W-1:0] push_data,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [ENTRY_W-1:0] head_r
);
  logic [ENTRY_W-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic [ENTRY_W-1:0] other_w;

  assign full = cnt_r[1];
  assign empty = (cnt_r == 2'h0);
  assign other_w = mem_r[~rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wp_r <= wp_r ^ push;
      rp_r <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // R03 status travels with data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_r <= '0;
    end else if (push && (empty || (pop && cnt_r == 2'h1))) begin
      head_r <= push_data;
    end else if (pop) begin
      head_r <= (cnt_r == 2'h2) ? other_w : '0;
    end
  end

  head_advance_a: assert property (@(posedge clk) disable iff (!rstn) // R03
    (pop && cnt_r == 2'h2) |=> head_r == $past(other_w))
    else $error("head did not advance to second entry");
endmodule : rx_buffer

// [verilog/rx_frame.sv]
// Purpose: oversampling serial frame receiver
// Assumes: rxd already synchronous, idle high
// Notes: start_o fires once per detected start edge
`timescale 1ns/1ps
module rx_frame
  import uart_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic rxd,
  input wire logic [4:0] ovs,
  input wire logic [11:0] baud_div,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic par_odd,
  output logic start_o,
  output logic done_o,
  output logic [8:0] data_o,
  output logic fe_o,
  output logic pe_o,
  output logic stop_o
);
  typedef enum logic [2:0] {IDLE, START, DATA, PAR, STOP} rx_state_e;
  rx_state_e st_r;
  logic [11:0] pre_r;
  logic [4:0] smp_r;
  logic [3:0] idx_r;
  logic tick;
  logic last;

  assign tick = (pre_r == 12'h000);
  assign last = (st_r == START) ? (smp_r == {1'b0, ovs[4:1]} - 5'h01) : (smp_r == ovs - 5'h01);

  // prescaler restarts at the start edge so sampling lands mid-bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
    end else if (st_r == IDLE || tick) begin
      pre_r <= baud_div;
    end else begin
      pre_r <= pre_r - 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= IDLE;
      smp_r <= '0;
      idx_r <= '0;
      data_o <= '0;
      fe_o <= 1'b0;
      pe_o <= 1'b0;
      stop_o <= 1'b0;
      start_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      start_o <= 1'b0;
      done_o <= 1'b0;
      if (st_r == IDLE) begin
        smp_r <= '0;
        if (en && !rxd) begin
          st_r <= START;
          start_o <= 1'b1;
        end
      end else if (tick) begin
        smp_r <= last ? 5'h00 : smp_r + 5'h01;
        if (last) begin
          unique case (st_r)
            START: begin
              idx_r <= '0;
              data_o <= '0;
              pe_o <= 1'b0;
              st_r <= rxd ? IDLE : DATA;
            end
            DATA: begin
              data_o[idx_r] <= rxd;
              idx_r <= idx_r + 4'h1;
              if (idx_r == nbits - 4'h1) begin
                st_r <= par_en ? PAR : STOP;
              end
            end
            // R07 parity check when enabled
            PAR: begin
              pe_o <= (^data_o) ^ rxd ^ par_odd;
              st_r <= STOP;
            end
            // R05 first stop bit sampled
            STOP: begin
              fe_o <= ~rxd;
              stop_o <= rxd;
              done_o <= 1'b1;
              st_r <= IDLE;
            end
            default: st_r <= IDLE;
          endcase
        end
      end
    end
  end

  parity_gate_a: assert property (@(posedge clk) disable iff (!rstn) // R07
    (st_r == STOP && !par_en && $stable(par_en) && $past(st_r) == STOP) |-> !pe_o)
    else $error("parity error without parity checking");
endmodule : rx_frame

// [verilog/uart_rx_ctrl.sv]
// Purpose: serial receive path, status flags and control over APB
// Assumes: RXD synchronous to SYS_CLK, transmitter lives outside
// Notes: APB answers in the second access cycle
//
// Operation
// R01: short characters read back zero-padded
// R02: software reads ninth bit and flags first
// R03: buffer carries ninth bit and error flags
// R04: transmit buffer empty set after reset
// R05: frame error follows head stop bit
// R06: overrun on start with full buffer, held char
// R07: parity error only when checking enabled
// R08: software writes zero to error flags
// R09: double speed halves divisor in async only
// R10: software keeps double speed off in sync
// R11: multiprocessor mode drops non-address frames
// R12: rx interrupt needs enable, global, flag
// R13: receive complete while buffer holds data
// R14: tx interrupt needs enable, global, flag
// R15: receive complete clears when buffer empties
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module uart_rx_ctrl
  import uart_rx_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial line and transmitter status
  input wire logic RXD,
  input wire logic TX_READY,
  input wire logic TX_DONE,
  // interrupts
  output logic IRQ,
  output logic RXC_IRQ,
  output logic TXC_IRQ,
  output logic UDRE_IRQ
);
  logic [7:0] ctlb_r;
  logic [7:0] ctlc_r;
  logic [11:0] baud_r;
  logic u2x_r;
  logic mpcm_r;
  logic txc_r;
  logic udre_r;
  logic [EV_W-1:0] ev_r;
  logic [EV_W-1:0] mask_r;
  logic hold_v_r;
  logic [ENTRY_W-1:0] hold_r;
  logic pop_ok_r;
  logic [31:0] rd_nxt;
  logic hit;
  logic xfer_done;
  logic wr_done;
  logic fifo_full;
  logic fifo_empty;
  logic [ENTRY_W-1:0] head;
  logic push;
  logic pop;
  logic [4:0] ovs;
  logic [2:0] sz_code;
  logic [3:0] nbits;
  logic rx_start;
  logic rx_done;
  logic [8:0] rx_data;
  logic rx_fe;
  logic rx_pe;
  logic rx_stop;
  logic addr_ind;
  logic accept;
  logic overrun;
  logic [7:0] sta_a;
  logic [7:0] data_mask;
  logic rxc_req;
  logic txc_req;
  logic [EV_W-1:0] ev_set;

  assign xfer_done = PSEL && PENABLE && PREADY;
  assign wr_done = xfer_done && PWRITE;
  assign sz_code = {ctlb_r[B_SZ2], ctlc_r[C_SZ_LO+1:C_SZ_LO]};
  assign nbits = char_bits(sz_code);
  assign data_mask = 8'hFF >> (4'h8 - ((nbits > 4'h8) ? 4'h8 : nbits));

  // R09 divisor 8 only in async double speed
  assign ovs = (u2x_r && !ctlc_r[C_SYNC]) ? OVS_DOUBLE : OVS_NORMAL;

  rx_frame u_frame (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .en(ctlb_r[B_RXEN]),
    .rxd(RXD),
    .ovs(ovs),
    .baud_div(baud_r),
    .nbits(nbits),
    .par_en(ctlc_r[C_PAR_EN]),
    .par_odd(ctlc_r[C_PAR_ODD]),
    .start_o(rx_start),
    .done_o(rx_done),
    .data_o(rx_data),
    .fe_o(rx_fe),
    .pe_o(rx_pe),
    .stop_o(rx_stop)
  );

  // R11 address indication per size
  assign addr_ind = (sz_code == SZ_NINE) ? rx_data[8] : rx_stop;
  assign push = hold_v_r && !fifo_full;
  // a fourth character arriving behind a waiting one is lost
  assign accept = rx_done && (!mpcm_r || addr_ind) && (!hold_v_r || push);
  // R06 overrun detection
  assign overrun = rx_start && hold_v_r && fifo_full;
  assign pop = xfer_done && !PWRITE && PADDR == OFF_DATA && pop_ok_r;

  // R03 ninth bit and flags stored
  rx_buffer u_buf (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .push(push),
    .push_data(hold_r),
    .pop(pop),
    .full(fifo_full),
    .empty(fifo_empty),
    .head_r(head)
  );

  // waiting character, the one behind the full buffer
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hold_v_r <= 1'b0;
      hold_r <= '0;
    end else if (accept) begin
      hold_v_r <= 1'b1;
      hold_r <= {1'b0, rx_pe, rx_fe, rx_data};
    end else if (push) begin
      hold_v_r <= 1'b0;
    end else if (overrun) begin
      hold_r[E_DOR] <= 1'b1;
    end
  end

  // R13 R15 receive complete tracks buffer
  // R05 R06 R07 flags shown from head entry
  assign sta_a = {!fifo_empty, txc_r, udre_r, head[E_FE], head[E_DOR], head[E_PE], u2x_r, mpcm_r};

  // R08 error flag bits not writable
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      u2x_r <= 1'b0;
      mpcm_r <= 1'b0;
      ctlb_r <= CTLB_RST;
      ctlc_r <= CTLC_RST;
      baud_r <= BAUD_RST;
      mask_r <= '0;
    end else if (wr_done) begin
      unique case (PADDR)
        OFF_STA: begin
          u2x_r <= PWDATA[A_U2X];
          mpcm_r <= PWDATA[A_MPCM];
        end
        OFF_CTLB: ctlb_r <= {PWDATA[7:2], 1'b0, PWDATA[B_TXB8]};
        OFF_CTLC: ctlc_r <= {2'h0, PWDATA[5:0]};
        OFF_BAUD: baud_r <= PWDATA[11:0];
        OFF_IRQ_MASK: mask_r <= PWDATA[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // transmit complete: set wins over write-one clear
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      txc_r <= 1'b0;
    end else if (TX_DONE) begin
      txc_r <= 1'b1;
    end else if (wr_done && PADDR == OFF_STA && PWDATA[A_TXC]) begin
      txc_r <= 1'b0;
    end
  end

  // R04 empty flag set from reset
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      udre_r <= UDRE_RST;
    end else begin
      udre_r <= TX_READY;
    end
  end

  // sticky events, a new event beats the clear
  assign ev_set = {TX_DONE, overrun, push && hold_r[E_FE], push};
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_r <= '0;
    end else if (wr_done && PADDR == OFF_IRQ_ST) begin
      ev_r <= (ev_r & ~PWDATA[EV_W-1:0]) | ev_set;
    end else begin
      ev_r <= ev_r | ev_set;
    end
  end

  // R12 receive interrupt gating
  assign rxc_req = ctlb_r[B_RXCIE] && ctlc_r[C_GIE] && !fifo_empty;
  // R14 transmit interrupt gating
  assign txc_req = ctlb_r[B_TXCIE] && ctlc_r[C_GIE] && txc_r;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
      RXC_IRQ <= 1'b0;
      TXC_IRQ <= 1'b0;
      UDRE_IRQ <= 1'b0;
    end else begin
      IRQ <= |(ev_r & mask_r);
      RXC_IRQ <= rxc_req;
      TXC_IRQ <= txc_req;
      UDRE_IRQ <= ctlb_r[B_UDRIE] && ctlc_r[C_GIE] && udre_r;
    end
  end

  // read mux
  always_comb begin
    hit = 1'b1;
    rd_nxt = '0;
    unique case (PADDR)
      // R01 unused upper bits read zero
      OFF_DATA: rd_nxt = {24'h0, head[7:0] & data_mask};
      OFF_STA: rd_nxt = {24'h0, sta_a};
      OFF_CTLB: rd_nxt = {24'h0, ctlb_r[7:2], head[8], ctlb_r[B_TXB8]};
      OFF_CTLC: rd_nxt = {24'h0, ctlc_r};
      OFF_BAUD: rd_nxt = {20'h0, baud_r};
      OFF_IRQ_ST: rd_nxt = {28'h0, ev_r};
      OFF_IRQ_MASK: rd_nxt = {28'h0, mask_r};
      default: hit = 1'b0;
    endcase
  end

  // answer in second access cycle; data captured in the first, pop at completion
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
      pop_ok_r <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_nxt;
        PSLVERR <= !hit;
        pop_ok_r <= !fifo_empty;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  sequence data_read_s;
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == OFF_DATA;
  endsequence

  udre_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R04
    $rose(RSTN) |-> udre_r)
    else $error("transmit empty flag not set after reset");

  data_pad_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R01
    data_read_s |-> (PRDATA[7:0] & ~data_mask) == 8'h00)
    else $error("unused data bits not zero");

  rxc_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R15
    (pop && !push && $past(push) == 1'b0 && u_buf.cnt_r == 2'h1) |=> !sta_a[A_RXC])
    else $error("receive complete stayed set on empty buffer");

  rxc_level_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R13
    push |=> sta_a[A_RXC])
    else $error("receive complete missing with data buffered");

  rx_irq_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R12
    ##1 RXC_IRQ == $past(ctlb_r[B_RXCIE] && ctlc_r[C_GIE] && sta_a[A_RXC]))
    else $error("receive interrupt gating wrong");

  tx_irq_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R14
    ##1 TXC_IRQ == $past(ctlb_r[B_TXCIE] && ctlc_r[C_GIE] && sta_a[A_TXC]))
    else $error("transmit interrupt gating wrong");

  overrun_mark_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R06
    (overrun && !accept) |=> hold_r[E_DOR] && hold_v_r)
    else $error("overrun not recorded on waiting character");

  frame_head_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R05
    (push && fifo_empty && !pop) |=> sta_a[A_FE] == $past(hold_r[E_FE]))
    else $error("frame error flag does not follow head");

  speed_div_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R09
    ctlc_r[C_SYNC] |-> ovs == OVS_NORMAL)
    else $error("double speed acted in synchronous mode");

  mp_filter_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R11
    (rx_done && mpcm_r && !addr_ind && !hold_v_r) |=> !hold_v_r)
    else $error("non-address frame accepted in multiprocessor mode");
endmodule : uart_rx_ctrl

// [dv/serial_tx_model.sv]
// Purpose: remote serial transmitter driving the receive line
// Assumes: send is called just after a rising clock edge
// Notes: line rests high between frames; one idle bit follows each stop
`timescale 1ns/1ps
module serial_tx_model (
  // line
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic par_on, input logic par,
                      input logic stop, input int bt);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    // lsb first, as the receiver shifts it in
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (bt) @(posedge clk);
    end
    if (par_on) begin
      rxd <= par;
      repeat (bt) @(posedge clk);
    end
    rxd <= stop;
    repeat (bt) @(posedge clk);
    rxd <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask : send
endmodule : serial_tx_model

// [dv/tb.sv]
// Purpose: register-level tests of the serial receive block
// Assumes: divider mostly zero, so one bit lasts 16 clocks, 8 at double speed, 32 at divider one
// Notes: expected values follow the register layout in the package
`timescale 1ns/1ps
module tb
  import uart_rx_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tx_done = 1'b0;
  logic tx_ready = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, irq, rxc_irq, txc_irq, udre_irq;
  logic [31:0] q;
  logic e;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  uart_rx_ctrl dut_u (.SYS_CLK(sys_clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd),
    .TX_READY(tx_ready), .TX_DONE(tx_done), .IRQ(irq), .RXC_IRQ(rxc_irq), .TXC_IRQ(txc_irq), .UDRE_IRQ(udre_irq));
  serial_tx_model tx_u (.clk(sys_clk), .rxd(rxd));

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // run is far shorter; a hang must not stall the regression
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // edge first, so release and next request never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic err;
    apb(1'b1, a, d, r, err);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic err;
    apb(1'b0, a, 32'h0, r, err);
    chk(r, x);
  endtask : rd

  task automatic poll(input logic [31:0] x);
    logic [31:0] r;
    logic err;
    r = 32'h0;
    for (int i = 0; i < 60 && r[A_RXC] !== 1'b1; i++) apb(1'b0, OFF_STA, 32'h0, r, err);
    chk(r, x);
  endtask : poll

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_STA, 32'h20);
    rd(OFF_CTLB, 32'h0);
    rd(OFF_CTLC, 32'h3);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(OFF_CTLB, 32'h10);
    tx_u.send(9'h0A5, 8, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hA0);
    rd(OFF_DATA, 32'hA5);
    rd(OFF_STA, 32'h20);
    wr(OFF_CTLC, 32'h0);
    tx_u.send(9'h015, 5, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hA0);
    rd(OFF_DATA, 32'h15);
    wr(OFF_CTLC, 32'h3);
    tx_u.send(9'h033, 8, 1'b0, 1'b0, 1'b0, 16);
    tx_u.send(9'h044, 8, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hB0);
    rd(OFF_DATA, 32'h33);
    rd(OFF_STA, 32'hA0);
    rd(OFF_DATA, 32'h44);
    wr(OFF_CTLC, 32'h7);
    tx_u.send(9'h003, 8, 1'b1, 1'b1, 1'b1, 16);
    poll(32'hA4);
    rd(OFF_DATA, 32'h3);
    tx_u.send(9'h003, 8, 1'b1, 1'b0, 1'b1, 16);
    poll(32'hA0);
    rd(OFF_DATA, 32'h3);
    // odd parity in sync mode, divider one
    wr(OFF_BAUD, 32'h1);
    rd(OFF_BAUD, 32'h1);
    wr(OFF_CTLC, 32'h1F);
    tx_u.send(9'h003, 8, 1'b1, 1'b1, 1'b1, 32);
    poll(32'hA0);
    rd(OFF_DATA, 32'h3);
    tx_u.send(9'h003, 8, 1'b1, 1'b0, 1'b1, 32);
    poll(32'hA4);
    rd(OFF_DATA, 32'h3);
    wr(OFF_BAUD, 32'h0);
    wr(OFF_CTLC, 32'h3);
    for (int i = 1; i <= 4; i++) tx_u.send(9'(i), 8, 1'b0, 1'b0, 1'b1, 16);
    rd(OFF_STA, 32'hA0);
    rd(OFF_DATA, 32'h1);
    rd(OFF_DATA, 32'h2);
    rd(OFF_STA, 32'hA8);
    rd(OFF_DATA, 32'h3);
    rd(OFF_STA, 32'h20);
    // nine bits: ninth and flags first
    wr(OFF_CTLB, 32'h14);
    tx_u.send(9'h1A5, 9, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hA0);
    rd(OFF_CTLB, 32'h16);
    rd(OFF_DATA, 32'hA5);
    rd(OFF_CTLB, 32'h14);
    wr(OFF_STA, 32'h1);
    tx_u.send(9'h0A5, 9, 1'b0, 1'b0, 1'b1, 16);
    rd(OFF_STA, 32'h21);
    tx_u.send(9'h1C3, 9, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hA1);
    rd(OFF_DATA, 32'hC3);
    wr(OFF_STA, 32'h0);
    // double speed, 8 clocks a bit
    wr(OFF_CTLB, 32'h10);
    wr(OFF_STA, 32'h2);
    tx_u.send(9'h05A, 8, 1'b0, 1'b0, 1'b1, 8);
    poll(32'hA2);
    rd(OFF_DATA, 32'h5A);
    wr(OFF_STA, 32'h0);
    wr(OFF_CTLB, 32'h90);
    wr(OFF_CTLC, 32'h23);
    tx_u.send(9'h066, 8, 1'b0, 1'b0, 1'b1, 16);
    poll(32'hA0);
    chk({31'h0, rxc_irq}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_CTLC, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, rxc_irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_ST, 32'h1F);
    rd(OFF_IRQ_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_DATA, 32'h66);
    wr(OFF_CTLB, 32'h50);
    wr(OFF_CTLC, 32'h23);
    tx_done <= 1'b1;
    @(posedge sys_clk);
    tx_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, txc_irq}, 32'h1);
    rd(OFF_STA, 32'h60);
    wr(OFF_STA, 32'h40);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, txc_irq}, 32'h0);
    rd(OFF_IRQ_ST, 32'h8);
    // empty interrupt follows transmitter readiness; ninth bit not writable
    wr(OFF_CTLB, 32'h2B);
    rd(OFF_CTLB, 32'h29);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, udre_irq}, 32'h1);
    tx_ready <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, udre_irq}, 32'h0);
    rd(OFF_STA, 32'h0);
    tx_ready <= 1'b1;
    complete_run();
  end
endmodule : tb
